// *** rtl/lsad_pkg.sv ***
package lsad_pkg;
	localparam int CLK_HZ = 40_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYC = CLK_HZ / MS_PER_S;
	localparam int DEBOUNCE_MS = 20;
	localparam int HOLD_MS = 1000;
	localparam int RESTORE_MIN = 2;
	localparam int RESTORE_MS = RESTORE_MIN * 60 * MS_PER_S;
	localparam int SETTLE_MS = 1000;
	localparam int AVG_WINDOW_H = 3;
	localparam int AVG_BUCKETS = 16;
	localparam int BUCKET_SAMPLES = 256;
	localparam int SAMPLE_MS = AVG_WINDOW_H * 3600 * MS_PER_S /
		(AVG_BUCKETS * BUCKET_SAMPLES);
	localparam int NLOADS = 6;
	localparam int NCOLS = 8;
	localparam int AVG_PCT = 80;
	localparam logic [7:0] RATING_30 = 8'h1E;
	localparam logic [7:0] RATING_20 = 8'h14;
	localparam logic [7:0] LIMIT_30 = 8'(int'(RATING_30) * AVG_PCT / 100);
	localparam logic [7:0] LIMIT_20 = 8'(int'(RATING_20) * AVG_PCT / 100);
	localparam logic [7:0] METER_MAX = 8'h63;
	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_STATUS = 12'h004;
	localparam logic [11:0] ADDR_LEVELS = 12'h008;
	localparam int CTRL_MGMT_EN = 0;
	localparam logic CTRL_MGMT_RESET = 1'b1;
	localparam int ST_TWENTY = 0;
	localparam int ST_AVG = 1;
	localparam int ST_GEN = 2;
	localparam int ST_SVC50 = 3;
	localparam int ST_BYPASS = 4;
	localparam int ST_RELAY_LSB = 8;
	localparam int ST_COL_LSB = 16;
	localparam int LV_AVG_LSB = 8;
	// Relay numbers, first shed first, one row per link column
	localparam logic [2:0] SHED_ORDER [NCOLS][NLOADS] = '{
		'{3'h6, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1},
		'{3'h4, 3'h6, 3'h5, 3'h3, 3'h2, 3'h1},
		'{3'h4, 3'h3, 3'h6, 3'h5, 3'h2, 3'h1},
		'{3'h4, 3'h3, 3'h2, 3'h6, 3'h5, 3'h1},
		'{3'h4, 3'h3, 3'h2, 3'h1, 3'h6, 3'h5},
		'{3'h6, 3'h4, 3'h5, 3'h3, 3'h2, 3'h1},
		'{3'h4, 3'h6, 3'h3, 3'h5, 3'h2, 3'h1},
		'{3'h4, 3'h3, 3'h6, 3'h2, 3'h5, 3'h1}
	};
	typedef enum logic [1:0] {
		LSAD_VIEW_TOTAL,
		LSAD_VIEW_LOAD,
		LSAD_VIEW_AVG
	} lsad_view_t;
	typedef enum logic {
		LSAD_SH_RUN,
		LSAD_SH_SETTLE
	} lsad_shed_t;
endpackage

// *** rtl/lsad_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsad_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic clk,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH < 2 || (1 << AW) < DEPTH) begin : g_bad
		$error("lsad_mem: bad depth");
	end

	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// No reset on the array: callers must not trust unwritten entries
	always_ff @(posedge clk) begin
		if (ce) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule
`default_nettype wire

// *** rtl/lsad_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsad_ctrl #(
	parameter int MS_CYC = lsad_pkg::MS_CYC,
	parameter int RESTORE_MS = lsad_pkg::RESTORE_MS,
	parameter int SAMPLE_MS = lsad_pkg::SAMPLE_MS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] load_amps,
	input wire logic gen_run_pin,
	input wire logic svc_240_pin,
	input wire logic button_pin,
	input wire logic order_link_high,
	input wire logic order_link_mid,
	input wire logic order_link_low,
	input wire logic spare_order_link,
	output logic [3:0] relay_ac_on,
	output logic [1:0] relay_dc_on,
	output logic [5:0] status_led,
	output logic [7:0] meter_value,
	output logic meter_blank,
	output logic meter_dp,
	output logic led_gen,
	output logic led_50a,
	output logic led_30a,
	output logic led_30_20
);
	localparam int NL = lsad_pkg::NLOADS;
	localparam int NPIN = 6;
	localparam int BW = $clog2(lsad_pkg::AVG_BUCKETS);
	localparam int SW = $clog2(lsad_pkg::BUCKET_SAMPLES);

	if (MS_CYC < 2 || MS_CYC > 65535 || RESTORE_MS < 1 ||
		RESTORE_MS > 262143 || SAMPLE_MS < 1 || SAMPLE_MS > 4095) begin : g_bad
		$error("lsad_ctrl: timing parameter out of range");
	end

	logic [NPIN-1:0] pin_raw, sync1, sync2;
	logic btn_raw, gen, s240, shore, bypass;
	logic [2:0] col;
	logic [15:0] ms_cnt;
	logic ms_tick;
	logic btn_stable, btn_held, btn_short, btn_hold;
	logic [4:0] deb_cnt;
	logic [9:0] hold_cnt;
	logic mgmt_en, twenty_mode, averaging;
	lsad_pkg::lsad_view_t view;
	logic [2:0] view_idx;
	logic [11:0] samp_ms;
	logic [SW-1:0] samp_cnt;
	logic [15:0] bucket_acc, next_acc;
	logic [BW-1:0] bucket_ptr;
	logic bucket_full, bucket_close;
	logic [7:0] bucket_old, bucket_new;
	logic [11:0] win_sum;
	logic [7:0] avg_amps, rating, lim80, threshold;
	lsad_pkg::lsad_shed_t sh_state;
	logic [2:0] shed_cnt;
	logic shed_dir;
	logic [9:0] settle_ms;
	logic [17:0] since_ms;
	logic [7:0] before_amps;
	logic [7:0] learned [NL];
	logic [5:0] relay_on, next_led;
	logic shed_go, restore_go;
	logic [2:0] shed_rel, restore_rel;
	logic [8:0] headroom;
	logic captured, access, addr_ok;

	// Two-stage synchronisers on every pin; spare link left unread
	assign pin_raw = {button_pin, gen_run_pin, svc_240_pin,
		order_link_high, order_link_mid, order_link_low};
	for (genvar i = 0; i < NPIN; i++) begin : g_sync
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				sync1[i] <= 1'b0;
				sync2[i] <= 1'b0;
			end else if (ce) begin
				sync1[i] <= pin_raw[i];
				sync2[i] <= sync1[i];
			end
		end
	end
	assign btn_raw = sync2[5];
	assign gen = sync2[4];
	assign s240 = sync2[3];
	assign col = sync2[2:0];
	assign shore = !gen && !s240;
	assign bypass = gen || s240 || !mgmt_en;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ms_cnt <= 16'h0000;
		end else if (ce) begin
			ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
		end
	end
	assign ms_tick = ms_cnt == 16'(MS_CYC - 1);

	// Button filter; a press counts on release unless it was a hold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			btn_stable <= 1'b0;
			btn_held <= 1'b0;
			deb_cnt <= 5'h00;
			hold_cnt <= 10'h000;
			btn_short <= 1'b0;
			btn_hold <= 1'b0;
		end else if (ce) begin
			btn_short <= 1'b0;
			btn_hold <= 1'b0;
			if (btn_raw == btn_stable) begin
				deb_cnt <= 5'h00;
			end else if (ms_tick) begin
				deb_cnt <= deb_cnt + 5'h01;
			end
			if (btn_raw != btn_stable && ms_tick &&
				deb_cnt == 5'(lsad_pkg::DEBOUNCE_MS - 1)) begin
				btn_stable <= btn_raw;
				hold_cnt <= 10'h000;
				btn_held <= 1'b0;
				btn_short <= !btn_raw && !btn_held;
			end else if (btn_stable && !btn_held && ms_tick) begin
				hold_cnt <= hold_cnt + 10'h001;
				if (hold_cnt == 10'(lsad_pkg::HOLD_MS - 1)) begin
					btn_held <= 1'b1;
					btn_hold <= 1'b1;
				end
			end
		end
	end

	// Service mode and display view
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			twenty_mode <= 1'b0;
			view <= lsad_pkg::LSAD_VIEW_TOTAL;
			view_idx <= 3'h0;
		end else if (ce) begin
			if (btn_hold && view == lsad_pkg::LSAD_VIEW_TOTAL) begin
				view <= lsad_pkg::LSAD_VIEW_LOAD;
				view_idx <= 3'h0;
			end else if (btn_short) begin
				case (view)
					lsad_pkg::LSAD_VIEW_TOTAL: begin
						twenty_mode <= !twenty_mode;
					end
					lsad_pkg::LSAD_VIEW_LOAD: begin
						if (view_idx == 3'(NL - 1)) begin
							view <= averaging ? lsad_pkg::LSAD_VIEW_AVG :
								lsad_pkg::LSAD_VIEW_TOTAL;
						end else begin
							view_idx <= view_idx + 3'h1;
						end
					end
					default: begin
						view <= lsad_pkg::LSAD_VIEW_TOTAL;
					end
				endcase
			end
		end
	end

	// Running average: 16 buckets of 256 samples span the window
	assign bucket_close = ms_tick && samp_ms == 12'(SAMPLE_MS - 1) &&
		samp_cnt == {SW{1'b1}};
	assign next_acc = bucket_acc + 16'(load_amps);
	assign bucket_new = next_acc[SW +: 8];
	lsad_mem #(
		.WIDTH(8),
		.DEPTH(lsad_pkg::AVG_BUCKETS)
	) u_buckets (
		.clk(pclk),
		.ce(ce),
		.wr_en(bucket_close),
		.wr_addr(bucket_ptr),
		.wr_data(bucket_new),
		.rd_addr(bucket_ptr),
		.rd_data(bucket_old)
	);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_ms <= 12'h000;
			samp_cnt <= '0;
			bucket_acc <= 16'h0000;
			bucket_ptr <= '0;
			bucket_full <= 1'b0;
			win_sum <= 12'h000;
		end else if (ce && ms_tick) begin
			samp_ms <= samp_ms == 12'(SAMPLE_MS - 1) ? 12'h000 :
				samp_ms + 12'h001;
			if (samp_ms == 12'(SAMPLE_MS - 1)) begin
				samp_cnt <= samp_cnt + 1'b1;
				bucket_acc <= bucket_close ? 16'h0000 : next_acc;
			end
			if (bucket_close) begin
				// Oldest bucket leaves as the newest enters
				win_sum <= win_sum + 12'(bucket_new) -
					(bucket_full ? 12'(bucket_old) : 12'h000);
				bucket_ptr <= bucket_ptr + 1'b1;
				if (bucket_ptr == {BW{1'b1}}) begin
					bucket_full <= 1'b1;
				end
			end
		end
	end
	assign avg_amps = win_sum[BW +: 8];

	assign rating = twenty_mode ? lsad_pkg::RATING_20 : lsad_pkg::RATING_30;
	assign lim80 = twenty_mode ? lsad_pkg::LIMIT_20 : lsad_pkg::LIMIT_30;
	assign threshold = averaging ? lim80 : rating;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			averaging <= 1'b0;
		end else if (ce) begin
			if (avg_amps > lim80) begin
				averaging <= 1'b1;
			end else if (avg_amps < lim80) begin
				averaging <= 1'b0;
			end
		end
	end

	// Shedding walks the selected column; restores run in reverse
	assign shed_rel = lsad_pkg::SHED_ORDER[col][shed_cnt];
	assign restore_rel = lsad_pkg::SHED_ORDER[col][shed_cnt - 3'h1];
	assign headroom = 9'(load_amps) + 9'(learned[shed_cnt - 3'h1]);
	assign shed_go = !bypass && sh_state == lsad_pkg::LSAD_SH_RUN &&
		load_amps > threshold && shed_cnt < 3'(NL);
	assign restore_go = !bypass && sh_state == lsad_pkg::LSAD_SH_RUN &&
		!shed_go && shed_cnt != 3'h0 && since_ms >= 18'(RESTORE_MS) &&
		headroom < 9'(threshold);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_state <= lsad_pkg::LSAD_SH_RUN;
			shed_cnt <= 3'h0;
			shed_dir <= 1'b0;
			settle_ms <= 10'h000;
			since_ms <= 18'h00000;
			before_amps <= 8'h00;
			relay_on <= 6'h3F;
			for (int i = 0; i < NL; i++) begin
				learned[i] <= 8'h00;
			end
		end else if (ce) begin
			if (ms_tick && since_ms < 18'(RESTORE_MS)) begin
				since_ms <= since_ms + 18'h00001;
			end
			if (bypass) begin
				relay_on <= 6'h3F;
				shed_cnt <= 3'h0;
				sh_state <= lsad_pkg::LSAD_SH_RUN;
			end else begin
				case (sh_state)
					lsad_pkg::LSAD_SH_RUN: begin
						if (shed_go) begin
							relay_on[shed_rel - 3'h1] <= 1'b0;
							before_amps <= load_amps;
							shed_cnt <= shed_cnt + 3'h1;
							shed_dir <= 1'b1;
							since_ms <= 18'h00000;
							settle_ms <= 10'h000;
							sh_state <= lsad_pkg::LSAD_SH_SETTLE;
						end else if (restore_go) begin
							relay_on[restore_rel - 3'h1] <= 1'b1;
							shed_cnt <= shed_cnt - 3'h1;
							shed_dir <= 1'b0;
							settle_ms <= 10'h000;
							sh_state <= lsad_pkg::LSAD_SH_SETTLE;
						end
					end
					default: begin
						// Let the current settle before judging again
						if (ms_tick) begin
							settle_ms <= settle_ms + 10'h001;
						end
						if (ms_tick &&
							settle_ms == 10'(lsad_pkg::SETTLE_MS - 1)) begin
							if (shed_dir) begin
								learned[shed_cnt - 3'h1] <=
									before_amps > load_amps ?
									before_amps - load_amps : 8'h00;
							end
							sh_state <= lsad_pkg::LSAD_SH_RUN;
						end
					end
				endcase
			end
		end
	end
	assign relay_ac_on = relay_on[3:0];
	assign relay_dc_on = relay_on[5:4];

	// Indicators ordered by shed position, uppermost sheds first
	for (genvar i = 0; i < NL; i++) begin : g_led
		always_comb begin
			if (view == lsad_pkg::LSAD_VIEW_LOAD) begin
				next_led[i] = view_idx == 3'(i);
			end else begin
				next_led[i] = relay_on[lsad_pkg::SHED_ORDER[col][i] - 3'h1];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_led <= 6'h3F;
			meter_value <= 8'h00;
			meter_blank <= 1'b0;
			meter_dp <= 1'b0;
			led_gen <= 1'b0;
			led_50a <= 1'b0;
			led_30a <= 1'b0;
			led_30_20 <= 1'b1;
		end else if (ce) begin
			status_led <= next_led;
			case (view)
				lsad_pkg::LSAD_VIEW_LOAD: begin
					meter_value <= learned[view_idx];
				end
				lsad_pkg::LSAD_VIEW_AVG: begin
					meter_value <= avg_amps;
				end
				default: begin
					meter_value <= load_amps > lsad_pkg::METER_MAX ?
						lsad_pkg::METER_MAX : load_amps;
				end
			endcase
			meter_blank <= s240 && view == lsad_pkg::LSAD_VIEW_TOTAL;
			meter_dp <= averaging;
			led_gen <= gen;
			led_50a <= s240;
			led_30a <= shore;
			led_30_20 <= !twenty_mode;
		end
	end

	// APB slave: data captured once per transfer, then pready
	assign access = psel && penable;
	assign pready = ce && captured;
	assign addr_ok = paddr == lsad_pkg::ADDR_CTRL ||
		paddr == lsad_pkg::ADDR_STATUS || paddr == lsad_pkg::ADDR_LEVELS;
	assign pslverr = pready && !addr_ok;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			captured <= 1'b0;
			prdata <= 32'h0000_0000;
			mgmt_en <= lsad_pkg::CTRL_MGMT_RESET;
		end else if (ce) begin
			if (access && captured) begin
				captured <= 1'b0;
				if (pwrite && paddr == lsad_pkg::ADDR_CTRL) begin
					mgmt_en <= pwdata[lsad_pkg::CTRL_MGMT_EN];
				end
			end else if (psel && !captured) begin
				captured <= 1'b1;
				prdata <= 32'h0000_0000;
				if (pwrite) begin
					prdata <= 32'h0000_0000;
				end else if (paddr == lsad_pkg::ADDR_CTRL) begin
					prdata[lsad_pkg::CTRL_MGMT_EN] <= mgmt_en;
				end else if (paddr == lsad_pkg::ADDR_STATUS) begin
					prdata[lsad_pkg::ST_TWENTY] <= twenty_mode;
					prdata[lsad_pkg::ST_AVG] <= averaging;
					prdata[lsad_pkg::ST_GEN] <= gen;
					prdata[lsad_pkg::ST_SVC50] <= s240;
					prdata[lsad_pkg::ST_BYPASS] <= bypass;
					prdata[lsad_pkg::ST_RELAY_LSB +: NL] <= relay_on;
					prdata[lsad_pkg::ST_COL_LSB +: 3] <= col;
				end else if (paddr == lsad_pkg::ADDR_LEVELS) begin
					prdata[7:0] <= load_amps;
					prdata[lsad_pkg::LV_AVG_LSB +: 8] <= avg_amps;
				end
			end
		end
	end

	dp_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> meter_dp == $past(averaging))
		else $error("decimal point does not follow averaging");
	bypass_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		(bypass && ce) ##1 (bypass && ce) |=> relay_on == 6'h3F)
		else $error("relays not all on under bypass");
	restore_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|(relay_on & ~$past(relay_on))) && !$past(bypass)
		|-> $past(since_ms) >= 18'(RESTORE_MS))
		else $error("load restored too soon");
	toggle_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		btn_short && ce && view == lsad_pkg::LSAD_VIEW_TOTAL && !btn_hold
		|=> twenty_mode != $past(twenty_mode))
		else $error("momentary press did not toggle");
	view_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
		btn_hold && ce && view == lsad_pkg::LSAD_VIEW_TOTAL
		|=> view == lsad_pkg::LSAD_VIEW_LOAD && view_idx == 3'h0 ##1
		!ce || status_led[0])
		else $error("hold did not enter stored view");
	svc_led_a: assert property (@(posedge pclk) disable iff (!presetn)
		ce |=> led_30_20 == !$past(twenty_mode))
		else $error("30/20 indicator wrong");
	thresh_sel_a: assert property (@(posedge pclk) disable iff (!presetn)
		threshold == (averaging ? (twenty_mode ? 8'h10 : 8'h18) :
		(twenty_mode ? 8'h14 : 8'h1E)))
		else $error("shed threshold wrong");
	shed_pick_a: assert property (@(posedge pclk) disable iff (!presetn)
		shed_go && ce |=> !relay_on[$past(shed_rel) - 3'h1] &&
		shed_cnt == $past(shed_cnt) + 3'h1)
		else $error("wrong relay shed");
	shed_need_a: assert property (@(posedge pclk) disable iff (!presetn)
		(|($past(relay_on) & ~relay_on))
		|-> $past(load_amps) > $past(threshold))
		else $error("shed without overload");
endmodule
`default_nettype wire

// *** sim/lsad_load_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module lsad_load_model (
	input wire logic [7:0] base_amps,
	input wire logic [3:0] relay_ac_on,
	input wire logic [1:0] relay_dc_on,
	output logic [7:0] load_amps
);
	// Sensor sums the feed at once, so each shed shows the same cycle
	always_comb begin
		load_amps = base_amps;
		// Mains loads on relays 1 to 4
		load_amps += relay_ac_on[0] ? 8'h01 : 8'h00;
		load_amps += relay_ac_on[1] ? 8'h01 : 8'h00;
		load_amps += relay_ac_on[2] ? 8'h01 : 8'h00;
		load_amps += relay_ac_on[3] ? 8'h06 : 8'h00;
		// Thermostat leads on relays 5 and 6
		load_amps += relay_dc_on[0] ? 8'h01 : 8'h00;
		load_amps += relay_dc_on[1] ? 8'h08 : 8'h00;
	end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int MSC = 10;
	localparam int RST_MS = 1500;
	localparam int DB = lsad_pkg::DEBOUNCE_MS * MSC + 60;
	localparam int SETTLE = lsad_pkg::SETTLE_MS * MSC;
	localparam int HOLD = lsad_pkg::HOLD_MS * MSC;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] load_amps, base_amps, meter_value;
	logic gen_run_pin, svc_240_pin, button_pin, e;
	logic lk_h, lk_m, lk_l, lk_s, meter_blank, meter_dp;
	logic led_gen, led_50a, led_30a, led_30_20;
	logic [3:0] relay_ac_on;
	logic [1:0] relay_dc_on;
	logic [5:0] status_led;
	int miscompares, tests_run;
	// Restore delay kept above settle so the two can be told apart
	lsad_ctrl #(.MS_CYC(MSC), .RESTORE_MS(RST_MS), .SAMPLE_MS(1)) dut_u (
		.pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.load_amps(load_amps), .gen_run_pin(gen_run_pin),
		.svc_240_pin(svc_240_pin), .button_pin(button_pin),
		.order_link_high(lk_h), .order_link_mid(lk_m),
		.order_link_low(lk_l), .spare_order_link(lk_s),
		.relay_ac_on(relay_ac_on), .relay_dc_on(relay_dc_on),
		.status_led(status_led), .meter_value(meter_value),
		.meter_blank(meter_blank), .meter_dp(meter_dp), .led_gen(led_gen),
		.led_50a(led_50a), .led_30a(led_30a), .led_30_20(led_30_20));
	lsad_load_model load_u (.base_amps(base_amps),
		.relay_ac_on(relay_ac_on), .relay_dc_on(relay_dc_on),
		.load_amps(load_amps));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic close_out;
		$display("TB: %0d checks, %0d mismatches", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// Idle edge after release so back-to-back calls never collide
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic press(input int len);
		button_pin <= 1'b1;
		cyc(len);
		button_pin <= 1'b0;
		cyc(DB);
	endtask
	task automatic t_reset;
		chk(relay_ac_on, 4'hF);
		chk(relay_dc_on, 2'h3);
		chk(status_led, 6'h3F);
		chk(led_30_20, 1'b1);
		chk(meter_dp, 1'b0);
		$display("TB: reset test done");
	endtask
	task automatic t_links;
		for (int k = 0; k < 8; k++) begin
			lk_h <= k[2];
			lk_m <= k[1];
			lk_l <= k[0];
			lk_s <= ~k[0];
			cyc(6);
			apb(1'b0, lsad_pkg::ADDR_STATUS, 32'h0);
			chk(q[18:16], k[2:0]);
			chk(q[0], 1'b0);
		end
		apb(1'b1, lsad_pkg::ADDR_STATUS, 32'hFFFFFFFF);
		apb(1'b0, lsad_pkg::ADDR_STATUS, 32'h0);
		chk({e, q[18:16]}, 4'h7);
		apb(1'b0, 12'h00C, 32'h0);
		chk(e, 1'b1);
		chk(q, 32'h0000_0000);
		apb(1'b1, lsad_pkg::ADDR_CTRL, 32'h0000_0000);
		apb(1'b0, lsad_pkg::ADDR_STATUS, 32'h0);
		chk(q[4], 1'b1);
		apb(1'b1, lsad_pkg::ADDR_CTRL, 32'h0000_0001);
		apb(1'b0, lsad_pkg::ADDR_CTRL, 32'h0);
		chk({e, q[0]}, 2'h1);
		$display("TB: link test done");
	endtask
	task automatic t_toggle;
		press(DB);
		chk(led_30_20, 1'b0);
		apb(1'b0, lsad_pkg::ADDR_STATUS, 32'h0);
		chk(q[0], 1'b1);
		press(DB);
		chk(led_30_20, 1'b1);
		apb(1'b0, lsad_pkg::ADDR_STATUS, 32'h0);
		chk(q[0], 1'b0);
		$display("TB: toggle test done");
	endtask
	task automatic t_shed;
		lk_h <= 1'b1;
		lk_m <= 1'b0;
		lk_l <= 1'b1;
		cyc(6);
		base_amps <= 8'h15;
		cyc(40);
		chk({relay_ac_on, relay_dc_on}, 6'h3D);
		chk(status_led, 6'h3E);
		cyc(SETTLE + 40);
		chk({relay_ac_on, relay_dc_on}, 6'h1D);
		chk(status_led, 6'h3C);
		cyc(SETTLE + 100);
		chk(meter_value, 8'h19);
		apb(1'b0, lsad_pkg::ADDR_LEVELS, 32'h0);
		chk(q[7:0], 8'h19);
		base_amps <= 8'h00;
		cyc(RST_MS * MSC - SETTLE - 600);
		chk(relay_ac_on, 4'h7);
		cyc(1000);
		chk(relay_ac_on, 4'hF);
		cyc(SETTLE + 800);
		chk(relay_dc_on, 2'h3);
		chk(status_led, 6'h3F);
		$display("TB: shed test done");
	endtask
	task automatic t_view;
		press(HOLD + DB);
		chk({status_led, meter_value}, 14'h0108);
		press(DB);
		chk({status_led, meter_value}, 14'h0206);
		for (int i = 2; i < 6; i++) begin
			press(DB);
			chk(status_led, 6'h01 << i);
		end
		press(DB);
		chk({status_led, meter_value}, 14'h3F12);
		$display("TB: view test done");
	endtask
	task automatic t_service;
		gen_run_pin <= 1'b1;
		cyc(6);
		base_amps <= 8'h70;
		cyc(100);
		chk({led_gen, led_50a, led_30a}, 3'h4);
		chk({relay_ac_on, relay_dc_on}, 6'h3F);
		chk(meter_value, 8'h63);
		// Heavy draw under bypass for several buckets lifts the average
		cyc(4 * lsad_pkg::BUCKET_SAMPLES * MSC);
		chk(meter_dp, 1'b1);
		apb(1'b0, lsad_pkg::ADDR_STATUS, 32'h0);
		chk(q[1], 1'b1);
		gen_run_pin <= 1'b0;
		svc_240_pin <= 1'b1;
		cyc(6);
		chk({led_gen, led_50a, led_30a, meter_blank}, 4'h5);
		chk({relay_ac_on, relay_dc_on}, 6'h3F);
		svc_240_pin <= 1'b0;
		base_amps <= 8'h00;
		cyc(6);
		chk({led_gen, led_50a, led_30a, meter_blank}, 4'h2);
		$display("TB: service test done");
	endtask
	initial begin
		cyc(90000);
		miscompares++;
		$display("ERROR at %0t: watchdog expired", $time);
		close_out();
	end
	initial begin
		miscompares = 0;
		tests_run = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{gen_run_pin, svc_240_pin, button_pin, base_amps} = '0;
		{lk_h, lk_m, lk_l, lk_s} = '0;
		cyc(2);
		t_reset();
		cyc(2);
		presetn <= 1'b1;
		cyc(3);
		t_links();
		t_toggle();
		t_shed();
		t_view();
		t_service();
		close_out();
	end
endmodule
`default_nettype wire
